// ===== hdl/dac_pkg.sv
// package of constants and carriers for the dual converter control block
//------------------------------------------------------------------
// Contract
// - one reference select bit, bit 6, both channels
// - select 0: internal reference off, external pins used
// - select 1: internal reference through per-channel trims
// - bit 9 doubles full scale for both
// - bit 7 selects single-ended or pseudo-differential
// - bit 4 selects binary or twos complement
// - 16-bit result, step is range over 65536
// - binary codes 0000, 8000, FFFF, saturating
// - twos complement codes 8000, 0000, 7FFF, saturating
// - both channels sampled together, positive minus negative
// - three registers, each writable and readable
// - writes commit at frame end after enough edges
// - readback command returns register next frame
//------------------------------------------------------------------
package dac_pkg;
	// configuration word field positions
	localparam int CFG_REF_SEL_BIT = 6;
	localparam int CFG_RANGE_BIT = 9;
	localparam int CFG_INPUT_BIT = 7;
	localparam int CFG_FORMAT_BIT = 4;
	localparam logic [11:0] CFG_RESET = 12'h000;
	localparam logic [8:0] TRIM_RESET = 9'h000;
	// falling serial clock edges that validate a write
	localparam logic [5:0] EDGE_MIN = 6'h20;
	localparam logic [4:0] WORD_EDGES = 5'h10;
	// command nibbles
	localparam logic [3:0] CMD_CFG_WR = 4'h8;
	localparam logic [3:0] CMD_TRIM_A_WR = 4'h9;
	localparam logic [3:0] CMD_TRIM_B_WR = 4'hA;
	localparam logic [3:0] CMD_TRIM_A_RD = 4'h1;
	localparam logic [3:0] CMD_TRIM_B_RD = 4'h2;
	localparam logic [3:0] CMD_CFG_RD = 4'h3;
	// code constants
	localparam logic [18:0] MID_OFFSET = 19'h08000;
	localparam logic [18:0] CODE_MAX = 19'h0FFFF;
	// local status bus byte offsets
	localparam logic [3:0] OFS_CFG = 4'h0;
	localparam logic [3:0] OFS_TRIM_A = 4'h4;
	localparam logic [3:0] OFS_TRIM_B = 4'h8;
	localparam logic [3:0] OFS_RESULT = 4'hC;

	// frame tracking, gray along idle, frame, commit
	typedef enum logic [1:0] {
		DAC_IDLE = 2'b00,
		DAC_FRAME = 2'b01,
		DAC_COMMIT = 2'b11
	} dac_fsm_t;

	// readback selection
	typedef enum logic [1:0] {
		DAC_RB_NONE = 2'b00,
		DAC_RB_A = 2'b01,
		DAC_RB_B = 2'b10,
		DAC_RB_CFG = 2'b11
	} dac_rb_t;

	// link side counters and input shifter
	typedef struct packed {
		logic [5:0] cnt;
		logic [15:0] sh;
	} dac_lk_t;

	// link side output pins
	typedef struct packed {
		logic out_a;
		logic out_b;
		logic oe;
	} dac_lo_t;

	// system side state
	typedef struct packed {
		logic cs_s1;
		logic cs_s2;
		logic cs_s3;
		dac_fsm_t fsm;
		logic [11:0] cfg;
		logic [8:0] trim_a;
		logic [8:0] trim_b;
		dac_rb_t rb;
		logic [15:0] res_a;
		logic [15:0] res_b;
		logic [15:0] tx_a;
		logic [15:0] tx_b;
		logic wait_n;
		logic [31:0] rdata;
	} dac_st_t;
endpackage

// ===== hdl/dac_ctrl.sv
// configuration, result coding and serial frame logic of the dual converter
module dac_ctrl
	import dac_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	// serial frame link
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic serial_in,
	output logic serial_out_a,
	output logic serial_out_b,
	output logic serial_out_oe,
	// converter core inputs, same clock, narrow-range step units
	input wire logic [17:0] ain_p_a,
	input wire logic [17:0] ain_m_a,
	input wire logic [17:0] ain_p_b,
	input wire logic [17:0] ain_m_b,
	// analog control outputs
	output logic internal_ref_source,
	output logic [8:0] ref_trim_chan_a,
	output logic [8:0] ref_trim_chan_b,
	output logic range_double_select,
	output logic input_type_select,
	output logic code_format_select,
	output logic sample_strobe,
	// avalon-mm status slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest
);

	//------------------------------------------------------------------
	// declarations
	//------------------------------------------------------------------
	dac_lk_t lk_reg; // link counters, cleared by system reset only
	dac_lk_t lk_next;
	dac_lo_t lo_reg; // link pins, also cleared while chip select is high
	dac_lo_t lo_next;
	dac_st_t st_reg; // system side state
	dac_st_t st_next;
	logic lo_rst; // link pin reset, frame's own end
	logic strobe_reg; // sample strobe flop
	logic strobe_next;
	logic [4:0] edge_idx; // word bit driven at this falling edge, 16 minus the edge count
	logic [15:0] rb_word; // readback word for the selected register
	logic [15:0] code_a; // coded result of channel a
	logic [15:0] code_b; // coded result of channel b

	// turn a pin pair into a 16-bit code
	function automatic logic [15:0] make_code(input logic [17:0] p, input logic [17:0] m,
		input logic [11:0] cfg);
		logic [19:0] d;
		logic [15:0] c;
		// one spare bit so a full-range input plus the half-scale offset cannot wrap negative
		d = {2'b00, p} - {2'b00, m}; // positive minus negative
		if (cfg[CFG_RANGE_BIT]) begin
			d = {d[19], d[19:1]}; // step doubles in the wide range
		end
		if (cfg[CFG_INPUT_BIT]) begin
			d = d + 20'(MID_OFFSET); // negative pin sits at half scale
		end
		if (d[19]) begin
			c = 16'h0000; // below range clamps low
		end else if (d > 20'(CODE_MAX)) begin
			c = 16'hFFFF; // above range clamps high
		end else begin
			c = d[15:0];
		end
		if (cfg[CFG_FORMAT_BIT]) begin
			c[15] = ~c[15]; // 0000 to 8000, FFFF to 7FFF
		end
		return c;
	endfunction

	//------------------------------------------------------------------
	// link domain: runs on the falling edges of the serial clock
	//------------------------------------------------------------------
	// the serial clock stands still between frames, so nothing here
	// waits for an edge after the last one of a frame
	assign lo_rst = sys_rst | cs_n;

	// readback or result words are held stable by the system side
	// throughout the frame, so the link may sample them directly
	always_comb begin
		lk_next = lk_reg;
		lo_next = lo_reg;
		edge_idx = 5'h00;
		// first edge of a frame restarts the count
		if (!lo_reg.oe) begin
			lk_next.cnt = 6'h01;
		end else if (lk_reg.cnt != 6'h3F) begin
			lk_next.cnt = lk_reg.cnt + 6'h01; // saturates, long frames stay valid
		end
		// command word enters on the first sixteen edges
		if (lk_next.cnt <= 6'({1'b0, WORD_EDGES})) begin
			lk_next.sh = {lk_reg.sh[14:0], serial_in};
		end
		lo_next.oe = 1'b1;
		// edge k drives bit 16-k, bits after the word read zero
		if (lk_next.cnt <= 6'({1'b0, WORD_EDGES})) begin
			edge_idx = WORD_EDGES - lk_next.cnt[4:0];
			lo_next.out_a = st_reg.tx_a[edge_idx[3:0]];
			lo_next.out_b = st_reg.tx_b[edge_idx[3:0]];
		end else begin
			lo_next.out_a = 1'b0;
			lo_next.out_b = 1'b0;
		end
	end

	// link counters survive the frame end for the commit
	always_ff @(negedge sclk or posedge sys_rst) begin
		if (sys_rst) begin
			lk_reg <= '0;
		end else begin
			lk_reg <= lk_next;
		end
	end

	// pins fall idle the moment chip select rises
	always_ff @(negedge sclk or posedge lo_rst) begin
		if (lo_rst) begin
			lo_reg <= '0;
		end else begin
			lo_reg <= lo_next;
		end
	end

	//------------------------------------------------------------------
	// system domain: frame tracking, registers, sampling, status bus
	//------------------------------------------------------------------
	assign code_a = make_code(ain_p_a, ain_m_a, st_reg.cfg);
	assign code_b = make_code(ain_p_b, ain_m_b, st_reg.cfg);

	// readback word carries the command nibble above the contents
	always_comb begin
		unique case (st_reg.rb)
			DAC_RB_A: rb_word = {CMD_TRIM_A_RD, st_reg.trim_a, 3'b000};
			DAC_RB_B: rb_word = {CMD_TRIM_B_RD, st_reg.trim_b, 3'b000};
			DAC_RB_CFG: rb_word = {CMD_CFG_RD, st_reg.cfg};
			DAC_RB_NONE: rb_word = 16'h0000;
		endcase
	end

	// next state of the system side
	always_comb begin
		st_next = st_reg;
		strobe_next = 1'b0;
		// chip select passes two flops; the third only feeds edge detect
		st_next.cs_s1 = cs_n;
		st_next.cs_s2 = st_reg.cs_s1;
		st_next.cs_s3 = st_reg.cs_s2;
		unique case (st_reg.fsm)
			DAC_IDLE: begin
				// frame start: both channels captured in one cycle
				if (st_reg.cs_s3 && !st_reg.cs_s2) begin
					st_next.res_a = code_a;
					st_next.res_b = code_b;
					strobe_next = 1'b1;
					st_next.fsm = DAC_FRAME;
				end
			end
			DAC_FRAME: begin
				// frame end: link is frozen, its word and count are stable
				if (!st_reg.cs_s3 && st_reg.cs_s2) begin
					st_next.fsm = DAC_COMMIT;
					st_next.rb = DAC_RB_NONE;
					// a short frame commits nothing, which is the abort
					if (lk_reg.cnt >= EDGE_MIN) begin
						unique case (lk_reg.sh[15:12])
							CMD_CFG_WR: st_next.cfg = lk_reg.sh[11:0];
							CMD_TRIM_A_WR: st_next.trim_a = lk_reg.sh[11:3];
							CMD_TRIM_B_WR: st_next.trim_b = lk_reg.sh[11:3];
							CMD_TRIM_A_RD: begin
								if (lk_reg.sh[11:0] == 12'h000) begin
									st_next.rb = DAC_RB_A;
								end
							end
							CMD_TRIM_B_RD: begin
								if (lk_reg.sh[11:0] == 12'h000) begin
									st_next.rb = DAC_RB_B;
								end
							end
							CMD_CFG_RD: begin
								if (lk_reg.sh[11:0] == 12'h000) begin
									st_next.rb = DAC_RB_CFG;
								end
							end
							default: begin
								// remaining nibbles are no operation
							end
						endcase
					end
				end
			end
			DAC_COMMIT: begin
				// load words for the next frame; a readback replaces result a
				if (st_reg.rb != DAC_RB_NONE) begin
					st_next.tx_a = rb_word;
					st_next.tx_b = 16'h0000;
				end else begin
					st_next.tx_a = st_reg.res_a;
					st_next.tx_b = st_reg.res_b;
				end
				st_next.fsm = DAC_IDLE;
			end
		endcase
		// status slave answers one cycle after the request arrives
		st_next.wait_n = 1'b0;
		if ((avs_read || avs_write) && !st_reg.wait_n) begin
			st_next.wait_n = 1'b1;
			unique case (avs_address)
				OFS_CFG: st_next.rdata = {20'h00000, st_reg.cfg};
				OFS_TRIM_A: st_next.rdata = {23'h000000, st_reg.trim_a};
				OFS_TRIM_B: st_next.rdata = {23'h000000, st_reg.trim_b};
				OFS_RESULT: st_next.rdata = {st_reg.res_b, st_reg.res_a};
				default: st_next.rdata = 32'h00000000; // unmapped reads zero
			endcase
		end
	end

	// registers of the system side; reset gives a 1 on the cs flops
	// so no false frame edge is seen after release
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_reg <= '{cs_s1: 1'b1, cs_s2: 1'b1, cs_s3: 1'b1, fsm: DAC_IDLE,
				cfg: CFG_RESET, trim_a: TRIM_RESET, trim_b: TRIM_RESET,
				rb: DAC_RB_NONE, default: '0};
			strobe_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			strobe_reg <= strobe_next;
		end
	end

	//------------------------------------------------------------------
	// outputs, all straight from flops
	//------------------------------------------------------------------
	assign serial_out_a = lo_reg.out_a;
	assign serial_out_b = lo_reg.out_b;
	assign serial_out_oe = lo_reg.oe;
	assign internal_ref_source = st_reg.cfg[CFG_REF_SEL_BIT]; // 0 powers it down
	assign ref_trim_chan_a = st_reg.trim_a; // trims only matter on internal reference
	assign ref_trim_chan_b = st_reg.trim_b;
	assign range_double_select = st_reg.cfg[CFG_RANGE_BIT];
	assign input_type_select = st_reg.cfg[CFG_INPUT_BIT];
	assign code_format_select = st_reg.cfg[CFG_FORMAT_BIT];
	assign sample_strobe = strobe_reg;
	// the status slave is read-only; writes complete and are dropped
	assign avs_readdata = st_reg.rdata;
	assign avs_waitrequest = ~st_reg.wait_n;

endmodule // dac_ctrl

// ===== testbench/dac_ctrl_monitor.sv
// assertion checker for the dual converter control block
module dac_ctrl_monitor
	import dac_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic cs_n,
	input wire logic serial_out_a,
	input wire logic serial_out_oe,
	input wire logic internal_ref_source,
	input wire logic [8:0] ref_trim_chan_a,
	input wire logic [8:0] ref_trim_chan_b,
	input wire logic range_double_select,
	input wire logic input_type_select,
	input wire logic code_format_select,
	input wire logic sample_strobe,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest
);
	//--------
	// bus, register and frame checks
	//--------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	// read data is taken at this edge
	wire logic rd_ok = avs_read && !avs_waitrequest;
	a_wait_one: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer late");
	a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("wait low too long");
	a_rd_cfg: assert property (rd_ok && avs_address == OFS_CFG |-> avs_readdata[31:12] == 20'h00000
		&& {avs_readdata[9], avs_readdata[7:6], avs_readdata[4]}
		== {range_double_select, input_type_select, internal_ref_source, code_format_select})
		else $error("config read differs from pins");
	a_rd_trim_a: assert property (rd_ok && avs_address == OFS_TRIM_A |-> avs_readdata == {23'h0, ref_trim_chan_a})
		else $error("trim a read differs");
	a_rd_trim_b: assert property (rd_ok && avs_address == OFS_TRIM_B |-> avs_readdata == {23'h0, ref_trim_chan_b})
		else $error("trim b read differs");
	// settings may only move after a frame has closed
	a_cfg_framed: assert property (!$stable({internal_ref_source, range_double_select, input_type_select,
		code_format_select, ref_trim_chan_a, ref_trim_chan_b}) |-> cs_n)
		else $error("setting changed inside a frame");
	a_pins_idle: assert property (cs_n |-> !serial_out_oe && !serial_out_a)
		else $error("data pin driven outside frame");
	a_sample_frame: assert property ($fell(cs_n) |-> ##[1:6] sample_strobe)
		else $error("no sample after frame start");
	c_result_rd: cover property (rd_ok && avs_address == OFS_RESULT);
	c_twos: cover property ($rose(code_format_select));
	c_wide: cover property ($rose(range_double_select));
endmodule // dac_ctrl_monitor

bind dac_ctrl dac_ctrl_monitor u_mon (.clk(clk), .sys_rst(sys_rst), .cs_n(cs_n), .serial_out_a(serial_out_a),
	.serial_out_oe(serial_out_oe), .internal_ref_source(internal_ref_source), .ref_trim_chan_a(ref_trim_chan_a),
	.ref_trim_chan_b(ref_trim_chan_b), .range_double_select(range_double_select),
	.input_type_select(input_type_select), .code_format_select(code_format_select),
	.sample_strobe(sample_strobe), .avs_address(avs_address), .avs_read(avs_read),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

// ===== testbench/dac_host.sv
// host controller model driving the serial frame link
module dac_host (
	output logic sclk,
	output logic cs_n,
	output logic serial_in,
	input wire logic serial_out_a,
	input wire logic serial_out_b
);
	timeunit 1ns;
	timeprecision 100ps;
	//--------
	// frame driver
	//--------
	// link clock idles high and stands still between frames
	initial begin
		sclk = 1'b1;
		cs_n = 1'b1;
		serial_in = 1'b0;
	end
	// one frame of n falls at 15 ns; word msb first, both data pins captured
	task automatic frame(input logic [15:0] w, input int n, output logic [15:0] ra, output logic [15:0] rb);
		ra = 16'h0000;
		rb = 16'h0000;
		#3.3 cs_n = 1'b0;
		#20;
		for (int k = 1; k <= n; k++) begin
			// past the word the line toggles, so a stale bit is never mistaken for data
			serial_in = (k <= 16) ? w[16 - k] : ~serial_in;
			#7.5 sclk = 1'b0;
			#7.5 if (k <= 16) {ra[16 - k], rb[16 - k]} = {serial_out_a, serial_out_b};
			sclk = 1'b1;
		end
		// fewer than 32 falls leaves the write unvalidated
		#20 cs_n = 1'b1;
		#700;
	endtask
endmodule // dac_host

// ===== testbench/dac_ctrl_bench.sv
// self-checking bench for the dual converter control block
module dac_ctrl_bench import dac_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	//--------
	// signals, clock and instances
	//--------
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [17:0] ain_p_a = 18'h0, ain_m_a = 18'h0, ain_p_b = 18'h0, ain_m_b = 18'h0;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0, avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	wire logic sclk, cs_n, serial_in, serial_out_a, serial_out_b, serial_out_oe, sample_strobe, avs_waitrequest;
	wire logic internal_ref_source, range_double_select, input_type_select, code_format_select;
	wire logic [8:0] ref_trim_chan_a, ref_trim_chan_b;
	wire logic [31:0] avs_readdata;
	int error_cnt = 0;
	int n_compared = 0;
	int cyc = 0;
	logic [15:0] r = 16'hBFD5; // lfsr seed 49109
	always #50 clk = ~clk;
	dac_ctrl u_dut (.clk(clk), .sys_rst(sys_rst), .sclk(sclk), .cs_n(cs_n), .serial_in(serial_in),
		.serial_out_a(serial_out_a), .serial_out_b(serial_out_b), .serial_out_oe(serial_out_oe),
		.ain_p_a(ain_p_a), .ain_m_a(ain_m_a), .ain_p_b(ain_p_b), .ain_m_b(ain_m_b),
		.internal_ref_source(internal_ref_source), .ref_trim_chan_a(ref_trim_chan_a),
		.ref_trim_chan_b(ref_trim_chan_b), .range_double_select(range_double_select),
		.input_type_select(input_type_select), .code_format_select(code_format_select),
		.sample_strobe(sample_strobe), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
	dac_host u_host (.sclk(sclk), .cs_n(cs_n), .serial_in(serial_in), .serial_out_a(serial_out_a),
		.serial_out_b(serial_out_b));
	//--------
	// helpers
	//--------
	function automatic logic [15:0] nx(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	// expected code: difference, halved when wide, offset when pseudo-differential, clamped
	function automatic logic [15:0] code(input logic [17:0] p, input logic [17:0] m, input logic [11:0] c);
		int d;
		d = int'(p) - int'(m);
		if (c[9]) d = d >>> 1;
		if (c[7]) d = d + 32768;
		if (d < 0) d = 0;
		if (d > 65535) d = 65535;
		return d[15:0] ^ {c[4], 15'h0};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// one avalon access, held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		{avs_read, avs_write, avs_address, avs_writedata} <= {!wr, wr, a, r, r};
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		d = avs_readdata;
		{avs_read, avs_write} <= 2'h0;
	endtask
	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// a hang ends the run as a mismatch
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			error_cnt++;
			stop_test();
		end
	end
	//--------
	// main sequence: every range, input and format combination
	//--------
	initial begin
		logic [31:0] d;
		logic [15:0] ra, rb, re;
		logic [11:0] cfg;
		logic [8:0] ta, tb;
		logic [3:0] rc;
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			r = nx(r);
			cfg = {2'h0, i[2], r[8], i[1], r[6:5], i[0], r[3:0]};
			r = nx(r);
			{ta, tb} = {r[8:0], r[15:7]};
			u_host.frame({CMD_CFG_WR, cfg}, 32, ra, rb);
			u_host.frame({CMD_TRIM_A_WR, ta, r[2:0]}, 32, ra, rb);
			u_host.frame({CMD_TRIM_B_WR, tb, r[3:1]}, 32, ra, rb);
			u_host.frame({CMD_CFG_WR, ~cfg}, 31, ra, rb);
			u_host.frame({4'hB, ~cfg}, 32, ra, rb);
			chk({internal_ref_source, range_double_select, input_type_select, code_format_select},
				{cfg[6], cfg[9], cfg[7], cfg[4]});
			chk({ref_trim_chan_a, ref_trim_chan_b}, {ta, tb});
			bus(1'b1, OFS_CFG, d);
			bus(1'b0, OFS_CFG, d);
			chk(d, {20'h0, cfg});
			bus(1'b0, OFS_TRIM_A, d);
			chk(d, {23'h0, ta});
			bus(1'b0, OFS_TRIM_B, d);
			chk(d, {23'h0, tb});
			bus(1'b0, 4'h2, d);
			chk(d, 32'h0);
			// corner inputs: bottom, top and equal pins among random ones
			r = nx(r);
			@(posedge clk);
			ain_p_a <= (i == 0) ? 18'h0 : (i == 1 || i == 3) ? 18'h3FFFF : {2'h0, r};
			ain_m_a <= {3'h0, r[14:0]};
			ain_p_b <= {2'h0, r ^ 16'h5A5A};
			ain_m_b <= (i == 2) ? {2'h0, r ^ 16'h5A5A} : {4'h0, r[13:0]};
			case (i % 3)
				0: {rc, re} = {CMD_CFG_RD, 4'h3, cfg};
				1: {rc, re} = {CMD_TRIM_A_RD, 4'h1, ta, 3'h0};
				default: {rc, re} = {CMD_TRIM_B_RD, 4'h2, tb, 3'h0};
			endcase
			u_host.frame({rc, 12'h000}, 32, ra, rb);
			u_host.frame(16'h0000, 32, ra, rb);
			chk({ra, rb}, {re, 16'h0});
			u_host.frame(16'h0000, 32, ra, rb);
			chk({ra, rb}, {code(ain_p_a, ain_m_a, cfg), code(ain_p_b, ain_m_b, cfg)});
			bus(1'b0, OFS_RESULT, d);
			chk(d, {code(ain_p_b, ain_m_b, cfg), code(ain_p_a, ain_m_a, cfg)});
			$display("combination %0d done", i);
		end
		stop_test();
	end
endmodule // dac_ctrl_bench
